// ==== hw/sfsp_status_bank.sv ====
`timescale 1ns/1ps
// Function
// - opcode 04h clears the write latch flag.
// - latch clears at reset and when status write, program or erase completes.
// - opcode 05h returns status byte one anytime, even while busy.
// - byte one: busy, latch, three protect bits, top/bottom, granularity, lock.
// - busy flag is 1 during status write, program or erase cycles.
// - latch 0 refuses status write, program and erase.
// - any protect bit set refuses writes and wipes into the protected area.
// - chip wipe runs only when all protect bits are 0.
// - top/bottom bit places protected region and boot-lock unit.
// - granularity bit picks 64KB block or 4KB sector unit.
// - lock bit with low protect pin freezes status and refuses status write.
// - protect bits change only outside hardware lock mode.
// - opcodes 09h or 35h return status byte two anytime.
// - byte two: erase susp, invert, security locks, program susp, quad io, zero.
// - all indicator bits are 0 after power-up and reset.
// - erase suspend sets erase-suspended flag, resume clears it.
// - program suspend sets program-suspended flag, resume clears it.
// - security locks are one-time set and refuse ops on their sector.
// - protect invert bit modifies the protected region layout.
// - quad io enable disables protect-pin and hold/reset pin functions.
// - opcode 06h sets the write latch flag.
// - after opcode 38h all instructions use four data lines until exit or reset.
module sfsp_status_bank (
	// system clock and reset
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic I_CE,
	// serial link
	input wire logic I_SCLK,
	input wire logic I_CS_N,
	input wire logic [3:0] I_DQ,
	output logic [3:0] O_DQ,
	output logic [3:0] O_DQ_OE,
	// protect pin
	input wire logic I_WP_N,
	// array operation requests
	input wire logic I_OP_REQ,
	input wire sfsp_pkg::sfsp_op_e I_OP_KIND,
	input wire logic I_OP_AREA_PROT,
	input wire logic I_OP_SEC,
	input wire logic [1:0] I_OP_SEC_IDX,
	input wire logic I_OP_DONE,
	input wire logic I_SUSPEND,
	input wire logic I_RESUME,
	output logic O_OP_GRANT,
	output logic O_OP_DENY,
	// protection state for the array
	output logic [7:0] O_STATUS_ONE,
	output logic [7:0] O_STATUS_TWO,
	output logic [2:0] O_BLOCK_PROTECT,
	output logic O_TOP_BOTTOM,
	output logic O_BOOT_GRAN,
	output logic O_PROTECT_INVERT,
	output logic O_QUAD_IO_ENABLE,
	output logic O_HOLD_RESET_EN,
	output logic O_HW_LOCK
);

	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] shift;
		logic [2:0] pos;
		logic [1:0] bytes;
		logic [7:0] opcode;
		logic [7:0] data_one;
		logic [7:0] data_two;
		logic [15:0] st_meta;
		logic [15:0] st_sync;
		logic seq;
	} sfsp_rise_s;

	typedef struct packed {
		logic [7:0] out_byte;
		logic [2:0] opos;
		logic drive;
	} sfsp_fall_s;

	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic wp_meta;
		logic wp_sync;
		logic busy;
		logic latch;
		logic [2:0] bp;
		logic tb;
		logic gran;
		logic lock;
		logic es;
		logic ps;
		logic inv;
		logic [2:0] sec;
		logic qe;
		logic op_erase;
		logic op_status;
		logic [sfsp_pkg::TIMER_W-1:0] timer;
		logic grant;
		logic deny;
		logic seq_seen;
	} sfsp_sys_s;

	sfsp_rise_s rise_reg;
	sfsp_rise_s rise_next;
	sfsp_fall_s fall_reg;
	sfsp_fall_s fall_next;
	sfsp_sys_s sys_reg;
	sfsp_sys_s sys_next;
	logic quad_reg;
	logic quad_next;
	logic live_reg;
	sfsp_rise_s rise_cur;

	logic [7:0] status_one;
	logic [7:0] status_two;
	logic [2:0] step;
	logic [7:0] new_shift;
	logic byte_done;
	logic is_read_one;
	logic is_read_two;
	logic reading;
	logic hw_lock;
	logic frame_end;
	logic frame_cmd;
	logic write_enable_cmd_cmd;
	logic protected_op;

	// ----------------------------------------
	// status byte composition
	// ----------------------------------------
	always_comb begin
		status_one = 8'h00;
		status_one[sfsp_pkg::SR1_BUSY] = sys_reg.busy;
		status_one[sfsp_pkg::SR1_LATCH] = sys_reg.latch;
		status_one[sfsp_pkg::SR1_BP_MSB:sfsp_pkg::SR1_BP_LSB] = sys_reg.bp;
		status_one[sfsp_pkg::SR1_TOP_BOTTOM] = sys_reg.tb;
		status_one[sfsp_pkg::SR1_GRAN] = sys_reg.gran;
		status_one[sfsp_pkg::SR1_LOCK] = sys_reg.lock;
		status_two = 8'h00;
		status_two[sfsp_pkg::SR2_ERASE_SUSP] = sys_reg.es;
		status_two[sfsp_pkg::SR2_INVERT] = sys_reg.inv;
		status_two[sfsp_pkg::SR2_SEC_LOCK_0] = sys_reg.sec[0];
		status_two[sfsp_pkg::SR2_SEC_LOCK_1] = sys_reg.sec[1];
		status_two[sfsp_pkg::SR2_SEC_LOCK_2] = sys_reg.sec[2];
		status_two[sfsp_pkg::SR2_PROG_SUSP] = sys_reg.ps;
		status_two[sfsp_pkg::SR2_QUAD_IO] = sys_reg.qe;
	end

	// ----------------------------------------
	// link side: input shifting on rising edge
	// ----------------------------------------
	always_comb begin
		// first rise of a frame starts the counters afresh
		rise_cur = rise_reg;
		if (!live_reg) begin
			rise_cur.pos = sfsp_pkg::POS_START;
			rise_cur.bytes = 2'h0;
		end
		step = quad_reg ? sfsp_pkg::STEP_QUAD : sfsp_pkg::STEP_SINGLE;
		new_shift = quad_reg ? {rise_cur.shift[3:0], I_DQ} : {rise_cur.shift[6:0], I_DQ[0]};
		byte_done = quad_reg ? (rise_cur.pos == sfsp_pkg::LAST_POS_QUAD)
			: (rise_cur.pos == sfsp_pkg::LAST_POS_SINGLE);
		rise_next = rise_cur;
		rise_next.seq = live_reg ? rise_reg.seq : !rise_reg.seq;
		rise_next.st_meta = {status_two, status_one};
		rise_next.st_sync = rise_reg.st_meta;
		rise_next.shift = new_shift;
		rise_next.pos = rise_cur.pos + step;
		if (byte_done) begin
			if (rise_cur.bytes == 2'h0) begin
				rise_next.opcode = new_shift;
			end else if (rise_cur.bytes == sfsp_pkg::BYTES_OPCODE_ONLY) begin
				rise_next.data_one = new_shift;
			end else if (rise_cur.bytes == sfsp_pkg::BYTES_ONE_DATA) begin
				rise_next.data_two = new_shift;
			end
			if (rise_cur.bytes != sfsp_pkg::BYTES_TWO_DATA) begin
				rise_next.bytes = rise_cur.bytes + 2'h1;
			end
		end
		quad_next = quad_reg;
		if (byte_done && rise_cur.bytes == 2'h0) begin
			if (!quad_reg && new_shift == sfsp_pkg::OP_QUAD_BUS_MODE) begin
				quad_next = 1'b1;
			end else if (quad_reg && new_shift == sfsp_pkg::OP_QUAD_EXIT) begin
				quad_next = 1'b0;
			end
		end
	end

	// frame contents stay readable by the system side while select is high
	always_ff @(posedge I_SCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rise_reg <= '0;
		end else if (!I_CS_N) begin
			rise_reg <= rise_next;
		end
	end

	// select high marks the next rise as the first of a new frame
	always_ff @(posedge I_SCLK or negedge I_NRST or posedge I_CS_N) begin
		if (!I_NRST || I_CS_N) begin
			live_reg <= 1'b0;
		end else begin
			live_reg <= 1'b1;
		end
	end

	// bus mode survives frames, only opcode FFh or reset leaves it
	always_ff @(posedge I_SCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			quad_reg <= 1'b0;
		end else if (!I_CS_N) begin
			quad_reg <= quad_next;
		end
	end

	// ----------------------------------------
	// link side: status output on falling edge
	// ----------------------------------------
	always_comb begin
		is_read_one = rise_reg.opcode == sfsp_pkg::OP_READ_STATUS;
		is_read_two = rise_reg.opcode == sfsp_pkg::OP_READ_STATUS_TWO_A
			|| rise_reg.opcode == sfsp_pkg::OP_READ_STATUS_TWO_B;
		reading = (is_read_one || is_read_two) && rise_reg.bytes != 2'h0;
		fall_next = fall_reg;
		fall_next.drive = reading;
		if (reading) begin
			if (fall_reg.opos == sfsp_pkg::POS_START) begin
				fall_next.out_byte = is_read_one ? rise_reg.st_sync[7:0]
					: rise_reg.st_sync[15:8];
			end else if (quad_reg) begin
				fall_next.out_byte = {fall_reg.out_byte[3:0], 4'h0};
			end else begin
				fall_next.out_byte = {fall_reg.out_byte[6:0], 1'b0};
			end
			fall_next.opos = fall_reg.opos + step;
		end
	end

	always_ff @(negedge I_SCLK or negedge I_NRST or posedge I_CS_N) begin
		if (!I_NRST || I_CS_N) begin
			fall_reg <= '0;
		end else begin
			fall_reg <= fall_next;
		end
	end

	always_comb begin
		if (quad_reg) begin
			O_DQ = fall_reg.out_byte[7:4];
			O_DQ_OE = fall_reg.drive ? 4'hf : 4'h0;
		end else begin
			O_DQ = {2'h0, fall_reg.out_byte[7], 1'b0};
			O_DQ_OE = fall_reg.drive ? 4'h2 : 4'h0;
		end
	end

	// ----------------------------------------
	// system side: status register state
	// ----------------------------------------
	always_comb begin
		hw_lock = sys_reg.lock && !sys_reg.wp_sync && !sys_reg.qe;
		frame_end = sys_reg.cs_sync && !sys_reg.cs_prev;
		// a frame without clocks must not replay the previous command
		frame_cmd = frame_end && rise_reg.pos == sfsp_pkg::POS_START
			&& rise_reg.seq != sys_reg.seq_seen;
		write_enable_cmd_cmd = frame_cmd && rise_reg.bytes == sfsp_pkg::BYTES_OPCODE_ONLY
			&& rise_reg.opcode == sfsp_pkg::OP_WRITE_ENABLE;
		if (I_OP_KIND == sfsp_pkg::OPK_CHIP) begin
			protected_op = |sys_reg.bp;
		end else if (I_OP_SEC) begin
			protected_op = I_OP_SEC_IDX != 2'h3 && sys_reg.sec[I_OP_SEC_IDX];
		end else begin
			protected_op = I_OP_AREA_PROT && |sys_reg.bp;
		end
		sys_next = sys_reg;
		sys_next.cs_meta = I_CS_N;
		sys_next.cs_sync = sys_reg.cs_meta;
		sys_next.cs_prev = sys_reg.cs_sync;
		sys_next.wp_meta = I_WP_N;
		sys_next.wp_sync = sys_reg.wp_meta;
		sys_next.grant = 1'b0;
		sys_next.deny = 1'b0;
		// link registers are still while select is high
		if (frame_end) begin
			sys_next.seq_seen = rise_reg.seq;
		end
		if (frame_cmd) begin
			if (rise_reg.bytes == sfsp_pkg::BYTES_OPCODE_ONLY
				&& rise_reg.opcode == sfsp_pkg::OP_WRITE_DISABLE) begin
				sys_next.latch = 1'b0;
			end else if (rise_reg.bytes == sfsp_pkg::BYTES_OPCODE_ONLY
				&& rise_reg.opcode == sfsp_pkg::OP_WRITE_ENABLE) begin
				sys_next.latch = 1'b1;
			end else if (rise_reg.opcode == sfsp_pkg::OP_WRITE_STATUS
				&& rise_reg.bytes != sfsp_pkg::BYTES_OPCODE_ONLY
				&& sys_reg.latch && !hw_lock && !sys_reg.busy) begin
				sys_next.bp = rise_reg.data_one[sfsp_pkg::SR1_BP_MSB:sfsp_pkg::SR1_BP_LSB];
				sys_next.tb = rise_reg.data_one[sfsp_pkg::SR1_TOP_BOTTOM];
				sys_next.gran = rise_reg.data_one[sfsp_pkg::SR1_GRAN];
				sys_next.lock = rise_reg.data_one[sfsp_pkg::SR1_LOCK];
				if (rise_reg.bytes == sfsp_pkg::BYTES_TWO_DATA) begin
					sys_next.inv = rise_reg.data_two[sfsp_pkg::SR2_INVERT];
					sys_next.qe = rise_reg.data_two[sfsp_pkg::SR2_QUAD_IO];
					sys_next.sec = sys_reg.sec | {rise_reg.data_two[sfsp_pkg::SR2_SEC_LOCK_2],
						rise_reg.data_two[sfsp_pkg::SR2_SEC_LOCK_1],
						rise_reg.data_two[sfsp_pkg::SR2_SEC_LOCK_0]};
				end
				sys_next.busy = 1'b1;
				sys_next.op_status = 1'b1;
				sys_next.timer = sfsp_pkg::WRITE_STATUS_CMD_CYCLES - sfsp_pkg::TIMER_ONE;
			end
		end
		// self-timed status write cycle
		if (sys_reg.busy && sys_reg.op_status) begin
			if (sys_reg.timer == sfsp_pkg::TIMER_ZERO) begin
				sys_next.busy = 1'b0;
				sys_next.latch = 1'b0;
				sys_next.op_status = 1'b0;
			end else begin
				sys_next.timer = sys_reg.timer - sfsp_pkg::TIMER_ONE;
			end
		end
		// array operations
		if (I_OP_REQ) begin
			if (sys_reg.latch && !sys_reg.busy && !sys_reg.es && !sys_reg.ps
				&& !protected_op) begin
				sys_next.grant = 1'b1;
				sys_next.busy = 1'b1;
				sys_next.op_erase = I_OP_KIND != sfsp_pkg::OPK_PAGE
					&& I_OP_KIND != sfsp_pkg::OPK_QUAD_PAGE;
			end else begin
				sys_next.deny = 1'b1;
			end
		end
		if (I_OP_DONE && sys_reg.busy && !sys_reg.op_status) begin
			sys_next.busy = 1'b0;
			sys_next.latch = 1'b0;
		end
		// write enable landing as a cycle completes still sets the latch
		if (write_enable_cmd_cmd) begin
			sys_next.latch = 1'b1;
		end
		if (I_SUSPEND && sys_reg.busy && !sys_reg.op_status) begin
			sys_next.busy = 1'b0;
			if (sys_reg.op_erase) begin
				sys_next.es = 1'b1;
			end else begin
				sys_next.ps = 1'b1;
			end
		end else if (I_RESUME && (sys_reg.es || sys_reg.ps)) begin
			sys_next.busy = 1'b1;
			sys_next.es = 1'b0;
			sys_next.ps = 1'b0;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sys_reg <= '0;
			sys_reg.cs_meta <= 1'b1;
			sys_reg.cs_sync <= 1'b1;
			sys_reg.cs_prev <= 1'b1;
			sys_reg.wp_meta <= 1'b1;
			sys_reg.wp_sync <= 1'b1;
			sys_reg.bp <= sfsp_pkg::BP_RESET;
			sys_reg.sec <= sfsp_pkg::SEC_RESET;
			sys_reg.tb <= sfsp_pkg::SR_BIT_RESET;
			sys_reg.inv <= sfsp_pkg::SR_BIT_RESET;
			sys_reg.qe <= sfsp_pkg::SR_BIT_RESET;
		end else if (I_CE) begin
			sys_reg <= sys_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign O_OP_GRANT = sys_reg.grant;
	assign O_OP_DENY = sys_reg.deny;
	assign O_STATUS_ONE = status_one;
	assign O_STATUS_TWO = status_two;
	assign O_BLOCK_PROTECT = sys_reg.bp;
	assign O_TOP_BOTTOM = sys_reg.tb;
	assign O_BOOT_GRAN = sys_reg.gran;
	assign O_PROTECT_INVERT = sys_reg.inv;
	assign O_QUAD_IO_ENABLE = sys_reg.qe;
	assign O_HOLD_RESET_EN = !sys_reg.qe;
	assign O_HW_LOCK = hw_lock;

endmodule

// ==== pkg/sfsp_pkg.sv ====
package sfsp_pkg;

	// ----------------------------------------
	// instruction opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_READ_STATUS_TWO_A = 8'h09;
	localparam logic [7:0] OP_READ_STATUS_TWO_B = 8'h35;
	localparam logic [7:0] OP_QUAD_BUS_MODE = 8'h38;
	localparam logic [7:0] OP_QUAD_EXIT = 8'hff;

	// ----------------------------------------
	// status byte one field positions
	// ----------------------------------------
	localparam int SR1_BUSY = 0;
	localparam int SR1_LATCH = 1;
	localparam int SR1_BP_LSB = 2;
	localparam int SR1_BP_MSB = 4;
	localparam int SR1_TOP_BOTTOM = 5;
	localparam int SR1_GRAN = 6;
	localparam int SR1_LOCK = 7;

	// ----------------------------------------
	// status byte two field positions
	// ----------------------------------------
	localparam int SR2_QUAD_IO = 1;
	localparam int SR2_PROG_SUSP = 2;
	localparam int SR2_SEC_LOCK_2 = 3;
	localparam int SR2_SEC_LOCK_1 = 4;
	localparam int SR2_SEC_LOCK_0 = 5;
	localparam int SR2_INVERT = 6;
	localparam int SR2_ERASE_SUSP = 7;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [2:0] BP_RESET = 3'h0;
	localparam logic SR_BIT_RESET = 1'b0;
	localparam logic [2:0] SEC_RESET = 3'h0;

	// ----------------------------------------
	// link frame counts
	// ----------------------------------------
	localparam logic [2:0] POS_START = 3'h0;
	localparam logic [2:0] STEP_SINGLE = 3'h1;
	localparam logic [2:0] STEP_QUAD = 3'h4;
	localparam logic [2:0] LAST_POS_SINGLE = 3'h7;
	localparam logic [2:0] LAST_POS_QUAD = 3'h4;
	localparam logic [1:0] BYTES_OPCODE_ONLY = 2'h1;
	localparam logic [1:0] BYTES_ONE_DATA = 2'h2;
	localparam logic [1:0] BYTES_TWO_DATA = 2'h3;

	// ----------------------------------------
	// status write cycle timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int WRITE_STATUS_CMD_TIME_NS = 2000;
	localparam int WRITE_STATUS_CMD_CYCLES_INT = (WRITE_STATUS_CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 8;
	localparam logic [TIMER_W-1:0] WRITE_STATUS_CMD_CYCLES = TIMER_W'(WRITE_STATUS_CMD_CYCLES_INT);
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'h00;
	localparam logic [TIMER_W-1:0] TIMER_ONE = 8'h01;

	// ----------------------------------------
	// array operation kinds
	// ----------------------------------------
	typedef enum logic [2:0] {
		OPK_PAGE,
		OPK_QUAD_PAGE,
		OPK_SECTOR,
		OPK_HALF_BLOCK,
		OPK_BLOCK,
		OPK_CHIP
	} sfsp_op_e;

endpackage

// ==== verif/sfsp_status_bank_props.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port checks of the status bank
// ----------------------------------------
module sfsp_status_bank_props (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_NRST,
	// watched inputs
	input wire logic I_CE,
	input wire logic I_CS_N,
	input wire logic I_OP_REQ,
	input wire sfsp_pkg::sfsp_op_e I_OP_KIND,
	input wire logic I_OP_AREA_PROT,
	input wire logic I_OP_DONE,
	input wire logic I_SUSPEND,
	input wire logic I_RESUME,
	// watched outputs
	input wire logic [3:0] O_DQ_OE,
	input wire logic O_OP_GRANT,
	input wire logic O_OP_DENY,
	input wire logic [7:0] O_STATUS_ONE,
	input wire logic [7:0] O_STATUS_TWO,
	input wire logic [2:0] O_BLOCK_PROTECT,
	input wire logic O_QUAD_IO_ENABLE,
	input wire logic O_HOLD_RESET_EN,
	input wire logic O_HW_LOCK
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);
	logic req;
	logic busy;
	logic susp;
	assign req = I_OP_REQ && I_CE;
	assign busy = O_STATUS_ONE[0];
	assign susp = O_STATUS_TWO[7] || O_STATUS_TWO[2];
	sequence s_granted;
		req ##1 O_OP_GRANT;
	endsequence
	sequence s_resumed;
		I_RESUME && I_CE && susp;
	endsequence
	AST_GRANT_BUSY: assert property (s_granted |-> busy && !O_OP_DENY)
		else $error("grant without busy");
	AST_NO_LATCH: assert property (req && !O_STATUS_ONE[1] |=> O_OP_DENY && !O_OP_GRANT)
		else $error("request without latch not denied");
	AST_AREA: assert property (req && I_OP_AREA_PROT && O_BLOCK_PROTECT != 3'h0 |=> O_OP_DENY)
		else $error("protected area not denied");
	AST_CHIP: assert property (req && I_OP_KIND == sfsp_pkg::OPK_CHIP
		&& O_BLOCK_PROTECT != 3'h0 |=> O_OP_DENY) else $error("chip wipe not denied");
	AST_ANSWER: assert property (O_OP_GRANT || O_OP_DENY |-> $past(req)
		&& !(O_OP_GRANT && O_OP_DENY)) else $error("answer without request");
	AST_PULSE: assert property (O_OP_GRANT |=> !O_OP_GRANT) else $error("grant too long");
	AST_DONE: assert property (I_OP_DONE && I_CE && busy |=> !busy && !O_STATUS_ONE[1])
		else $error("done did not clear busy and latch");
	AST_SUSPEND: assert property (I_SUSPEND && I_CE && busy |=> susp && !busy)
		else $error("suspend flag not set");
	AST_RESUME: assert property (s_resumed |=> busy && !susp) else $error("resume failed");
	AST_RESERVED: assert property (!O_STATUS_TWO[0]) else $error("reserved bit set");
	AST_FIELDS: assert property (O_BLOCK_PROTECT == O_STATUS_ONE[4:2])
		else $error("protect field mismatch");
	AST_PINS: assert property (O_HOLD_RESET_EN == !O_QUAD_IO_ENABLE && (!O_HW_LOCK
		|| (O_STATUS_ONE[7] && !O_QUAD_IO_ENABLE))) else $error("pin function wrong");
	AST_OE_IDLE: assert property (I_CS_N [*3] |-> O_DQ_OE == 4'h0) else $error("drive idle");
endmodule

bind sfsp_status_bank sfsp_status_bank_props u_sfsp_status_bank_props (
	.I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(I_CE), .I_CS_N(I_CS_N), .I_OP_REQ(I_OP_REQ),
	.I_OP_KIND(I_OP_KIND), .I_OP_AREA_PROT(I_OP_AREA_PROT), .I_OP_DONE(I_OP_DONE),
	.I_SUSPEND(I_SUSPEND), .I_RESUME(I_RESUME), .O_DQ_OE(O_DQ_OE), .O_OP_GRANT(O_OP_GRANT),
	.O_OP_DENY(O_OP_DENY), .O_STATUS_ONE(O_STATUS_ONE), .O_STATUS_TWO(O_STATUS_TWO),
	.O_BLOCK_PROTECT(O_BLOCK_PROTECT), .O_QUAD_IO_ENABLE(O_QUAD_IO_ENABLE),
	.O_HOLD_RESET_EN(O_HOLD_RESET_EN), .O_HW_LOCK(O_HW_LOCK));

// ==== verif/sfsp_spi_host.sv ====
`timescale 1ns/1ps
module sfsp_spi_host (
	// serial link
	output logic o_sclk,
	output logic o_cs_n,
	output logic [3:0] o_dq,
	input wire logic [3:0] i_dq
);
	logic quad;
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_dq = 4'h0;
		quad = 1'b0;
	end
	// ----------------------------------------
	// one frame: opcode, data bytes, read bytes
	// ----------------------------------------
	task automatic xfer(input logic [7:0] op, input int nw, input logic [15:0] wd,
		input int cut, input int nr, output logic [15:0] rd);
		logic [23:0] s;
		int st;
		s = {op, wd};
		st = quad ? 4 : 1;
		rd = 16'h0;
		o_cs_n = 1'b0;
		for (int i = 0; i < (nw + 1) * 8 - cut; i += st) begin
			o_dq = quad ? s[23 - i -: 4] : {~o_dq[3:1], s[23 - i]};
			#6 o_sclk = 1'b1;
			#6 o_sclk = 1'b0;
		end
		for (int i = 0; i < nr * 8; i += st) begin
			o_dq = ~o_dq;
			#6 o_sclk = 1'b1;
			rd = quad ? {rd[11:0], i_dq} : {rd[14:0], i_dq[1]};
			#6 o_sclk = 1'b0;
		end
		#6 o_cs_n = 1'b1;
		o_dq = ~o_dq;
		if (op == 8'h38 && !quad && cut == 0) quad = 1'b1;
		else if (op == 8'hff && quad && cut == 0) quad = 1'b0;
		#900;
	endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
	logic I_CLK = 0, I_NRST = 1, I_CE = 1, I_WP_N = 1, I_OP_REQ = 0, I_OP_AREA_PROT = 0;
	logic I_OP_SEC = 0, I_OP_DONE = 0, I_SUSPEND = 0, I_RESUME = 0;
	logic [1:0] I_OP_SEC_IDX = 2'h3;
	sfsp_pkg::sfsp_op_e I_OP_KIND = sfsp_pkg::OPK_PAGE;
	logic sclk, cs_n, O_OP_GRANT, O_OP_DENY, O_HOLD_RESET_EN, O_HW_LOCK;
	logic O_TOP_BOTTOM, O_BOOT_GRAN, O_PROTECT_INVERT, O_QUAD_IO_ENABLE;
	logic [3:0] h_dq, dq_w, O_DQ, O_DQ_OE;
	logic [7:0] O_STATUS_ONE, O_STATUS_TWO, rd8;
	logic [31:0] seed = 32'd5329;
	logic [15:0] rd;
	logic [31:0] rv;
	logic [2:0] sec = 3'h0;
	int n_fail = 0, samples_checked = 0;
	always #50 I_CLK = ~I_CLK;
	assign dq_w = (O_DQ_OE & O_DQ) | (~O_DQ_OE & h_dq);
	sfsp_spi_host u_sfsp_spi_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_dq(h_dq), .i_dq(dq_w));
	sfsp_status_bank u_sfsp_status_bank (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(I_CE),
		.I_SCLK(sclk), .I_CS_N(cs_n), .I_DQ(dq_w), .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE),
		.I_WP_N(I_WP_N), .I_OP_REQ(I_OP_REQ), .I_OP_KIND(I_OP_KIND),
		.I_OP_AREA_PROT(I_OP_AREA_PROT), .I_OP_SEC(I_OP_SEC), .I_OP_SEC_IDX(I_OP_SEC_IDX),
		.I_OP_DONE(I_OP_DONE), .I_SUSPEND(I_SUSPEND), .I_RESUME(I_RESUME),
		.O_OP_GRANT(O_OP_GRANT), .O_OP_DENY(O_OP_DENY), .O_STATUS_ONE(O_STATUS_ONE),
		.O_STATUS_TWO(O_STATUS_TWO), .O_BLOCK_PROTECT(), .O_TOP_BOTTOM(O_TOP_BOTTOM),
		.O_BOOT_GRAN(O_BOOT_GRAN), .O_PROTECT_INVERT(O_PROTECT_INVERT),
		.O_QUAD_IO_ENABLE(O_QUAD_IO_ENABLE), .O_HOLD_RESET_EN(O_HOLD_RESET_EN),
		.O_HW_LOCK(O_HW_LOCK));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_two(input logic [7:0] v, input logic [2:0] s);
		return {1'b0, v[6], s, 1'b0, v[1], 1'b0};
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic done_test(input string s);
		$display("test %s done", s);
	endtask
	task automatic cmd(input logic [7:0] op, input int nr);
		u_sfsp_spi_host.xfer(op, 0, 16'h0, 0, nr, rd);
		rd8 = rd[7:0];
	endtask
	task automatic write_status_cmd(input logic [7:0] a, input logic [7:0] b, input logic acc);
		int k;
		cmd(8'h06, 0);
		u_sfsp_spi_host.xfer(8'h01, 2, {a, b}, 0, 0, rd);
		for (k = 0; k < 20; k++) begin
			cmd(8'h05, 1);
			if (k == 0) `CHK("busy_latch", {1'b1, acc}, rd8[1:0])
			if (!rd8[0]) break;
		end
		if (k == 20) begin
			n_fail++;
			finish_test();
		end
	endtask
	task automatic op(input int k, input logic prot, input logic s, input logic [1:0] idx,
		input logic ce, input logic [1:0] gd);
		@(negedge I_CLK);
		I_OP_KIND = sfsp_pkg::sfsp_op_e'(k);
		I_OP_AREA_PROT = prot;
		I_OP_SEC = s;
		I_OP_SEC_IDX = idx;
		I_CE = ce;
		I_OP_REQ = 1'b1;
		@(negedge I_CLK);
		I_OP_REQ = 1'b0;
		I_CE = 1'b1;
		`CHK("grant_deny", gd, {O_OP_GRANT, O_OP_DENY})
	endtask
	task automatic pulse(input int w);
		@(negedge I_CLK);
		I_OP_DONE = (w == 0);
		I_SUSPEND = (w == 1);
		I_RESUME = (w == 2);
		@(negedge I_CLK);
		{I_OP_DONE, I_SUSPEND, I_RESUME} = 3'h0;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		// a real falling edge, so the link-side flops see the reset
		#1 I_NRST = 1'b0;
		repeat (20) @(negedge I_CLK);
		I_NRST = 1'b1;
		`CHK("sr1_reset", 8'h00, O_STATUS_ONE)
		`CHK("sr2_reset", 8'h00, O_STATUS_TWO)
		repeat (3) @(negedge I_CLK);
		#7;
		cmd(8'h06, 0);
		cmd(8'h05, 2);
		`CHK("sr1_repeat", 16'h0202, rd)
		cmd(8'h04, 0);
		cmd(8'h05, 1);
		`CHK("sr1_wd", 8'h00, rd8)
		u_sfsp_spi_host.xfer(8'h06, 0, 16'h0, 3, 0, rd);
		cmd(8'h05, 1);
		`CHK("sr1_partial", 8'h00, rd8)
		op(0, 0, 0, 2'h3, 1, 2'b01);
		done_test("latch");
		for (int i = 0; i < 6; i++) begin
			rv = xs();
			write_status_cmd(rv[7:0] & 8'hfc, rv[15:8], 1);
			sec = sec | rv[13:11];
			cmd(8'h05, 1);
			`CHK("sr1_write", rv[7:0] & 8'hfc, rd8)
			`CHK("bound_fields", rv[6:5], {O_BOOT_GRAN, O_TOP_BOTTOM})
			`CHK("two_fields", {rv[14], rv[9]}, {O_PROTECT_INVERT, O_QUAD_IO_ENABLE})
			cmd(i[0] ? 8'h09 : 8'h35, 1);
			`CHK("sr2_write", exp_two(rv[15:8], sec), rd8)
		end
		done_test("random");
		write_status_cmd(8'h84, 8'h20, 1);
		sec = sec | 3'h4;
		@(negedge I_CLK);
		I_WP_N = 1'b0;
		repeat (3) @(negedge I_CLK);
		`CHK("hw_lock", 1'b1, O_HW_LOCK)
		write_status_cmd(8'h00, 8'h00, 0);
		cmd(8'h05, 1);
		`CHK("sr1_locked", 8'h86, rd8)
		op(0, 1, 0, 2'h3, 1, 2'b01);
		op(5, 0, 0, 2'h3, 1, 2'b01);
		op(2, 0, 1, 2'h0, 1, 2'b01);
		op(0, 0, 0, 2'h3, 0, 2'b00);
		@(negedge I_CLK);
		I_WP_N = 1'b1;
		repeat (3) @(negedge I_CLK);
		write_status_cmd(8'h80, 8'h02, 1);
		@(negedge I_CLK);
		I_WP_N = 1'b0;
		repeat (3) @(negedge I_CLK);
		`CHK("qe_pins", 2'b00, {O_HW_LOCK, O_HOLD_RESET_EN})
		done_test("lock");
		for (int k = 0; k < 6; k++) begin
			cmd(8'h06, 0);
			op(k, 0, 0, 2'h3, 1, 2'b10);
			`CHK("run", 2'b11, O_STATUS_ONE[1:0])
			pulse(1);
			`CHK("suspended", (k < 2) ? 8'h04 : 8'h80, O_STATUS_TWO & 8'h84)
			pulse(2);
			`CHK("resumed", 8'h00, O_STATUS_TWO & 8'h84)
			pulse(0);
			`CHK("finished", 2'b00, O_STATUS_ONE[1:0])
		end
		done_test("ops");
		cmd(8'h38, 0);
		cmd(8'h05, 1);
		`CHK("sr1_quad", 8'h80, rd8)
		cmd(8'hff, 0);
		cmd(8'h09, 1);
		`CHK("sr2_single", exp_two(8'h02, sec), rd8)
		done_test("quad");
		finish_test();
	end
endmodule
